/* inc/usart_pkg.sv */
// Shared constants, register map and state encodings of the serial port
// Overview of operation
// R01 - Wake enable parks the receiver; a falling receive-line edge is the wake event.
// R02 - Remote node sends an all-zero first character when wake-up is used.
// R03 - Next rising receive-line edge after the wake event clears wake enable.
// R04 - Reading received data clears the receive flag; that data is discarded.
// R05 - Software checks receiver idle before arming wake enable.
// R06 - Wake enable auto-clear works even while the clock enable is low.
// R07 - Break is a start bit, twelve zero bits, then a stop bit.
// R08 - Break goes out when send-break and transmit enable are set at shift load.
// R09 - Buffer value written for a break is ignored; zeros are shifted instead.
// R10 - Hardware clears send-break after the break stop bit; next byte goes normally.
// R11 - Shift-register-empty reports break activity like normal characters.
// R12 - Header software sets enables, writes a dummy byte, then the sync byte.
// R13 - First break-receive method runs the baud rate at 9/13 of nominal.
// R14 - Wake path sees two edges, raises the receive flag, then takes the next byte.
// R15 - Software may enable auto-baud after a break once the transmit flag shows.
// R16 - Clocked master needs clock-source and clocked-mode bits; port enable remaps pins.
// R17 - Clocked mode is half duplex: receiving blocks sending and sending blocks receiving. Code: a receive request stops a send; no clocked receive.
// R18 - Master drives the shift clock; polarity bit selects its idle level.
// R19 - Shift register reloads only after its last bit, at once if data waits.
// R20 - Buffer to shift register move takes one cycle, then transmit flag sets.
// R21 - Transmit flag ignores its enable, cannot be cleared, clears on buffer write.
// R22 - Shift-register-empty is read-only, set while the shift register is empty.
// R23 - Master transmit setup: divisor, mode, options, transmit enable, then data.
// R24 - Shift clock rate comes from the high and low divisor registers.
`default_nettype none

package usart_pkg;

	localparam int ADDR_W = 3;

	localparam logic [ADDR_W-1:0] OFS_RCV_STATUS = 3'h0;
	localparam logic [ADDR_W-1:0] OFS_TX_BUFFER = 3'h1;
	localparam logic [ADDR_W-1:0] OFS_TX_STATUS = 3'h2;
	localparam logic [ADDR_W-1:0] OFS_BAUD_CTRL = 3'h3;
	localparam logic [ADDR_W-1:0] OFS_DIV_HIGH = 3'h4;
	localparam logic [ADDR_W-1:0] OFS_DIV_LOW = 3'h5;
	localparam logic [ADDR_W-1:0] OFS_RCV_DATA = 3'h6;
	localparam logic [ADDR_W-1:0] OFS_FLAGS = 3'h7;

	// Receive status and control fields
	localparam int BIT_PORT_EN = 7;
	localparam int BIT_RX_NINE = 6;
	localparam int BIT_SINGLE_RX = 5;
	localparam int BIT_CONT_RX = 4;
	localparam logic [7:0] RCV_WMASK = 8'hF8;

	// Transmit status and control fields
	localparam int BIT_CLK_MASTER = 7;
	localparam int BIT_TX_NINE = 6;
	localparam int BIT_TX_EN = 5;
	localparam int BIT_CLOCKED = 4;
	localparam int BIT_SEND_BREAK = 3;
	localparam int BIT_HIGH_SPEED = 2;
	localparam int BIT_TX_NINTH = 0;
	localparam logic [7:0] TX_WMASK = 8'hF5;

	// Baud control fields
	localparam int BIT_CLK_POL = 4;
	localparam int BIT_WIDE_DIV = 3;
	localparam int BIT_WAKE_EN = 1;
	localparam logic [7:0] BAUD_WMASK = 8'h39;

	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [15:0] DIV_RESET = 16'h0000;

	// Half-bit prescale per mode: clocked, plain, one speed-up, both speed-ups
	localparam logic [5:0] PRE_CLOCKED = 6'h02;
	localparam logic [5:0] PRE_PLAIN = 6'h20;
	localparam logic [5:0] PRE_FAST = 6'h08;
	localparam logic [5:0] PRE_FASTEST = 6'h02;

	// Break: start, twelve zeros, stop, sent LSB first
	localparam logic [13:0] BREAK_FRAME = 14'h2000;
	localparam logic [3:0] BREAK_BITS = 4'hE;
	localparam logic [3:0] ASYNC_BITS = 4'hA;
	localparam logic [3:0] CLOCKED_BITS = 4'h8;
	localparam logic [4:0] RX_LAST8 = 5'h09;
	localparam logic [4:0] RX_LAST9 = 5'h0A;

	typedef enum logic [2:0] {
		TX_IDLE = 3'b001,
		TX_LOAD = 3'b010,
		TX_SHIFT = 3'b100
	} tx_state_t;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b01,
		RX_BUSY = 2'b10
	} rx_state_t;

endpackage

`default_nettype wire

/* logic/baud_gen.sv */
// Baud divisor counter producing one tick per half bit
`default_nettype none

module baud_gen
	import usart_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic restart,
	input wire logic [15:0] divisor,
	input wire logic [5:0] prescale,
	output logic tick
);

	logic [15:0] cnt_q;
	logic [5:0] pre_q;

	wire base_end = (cnt_q == divisor);
	wire pre_end = (pre_q == (prescale - 6'h01));

	assign tick = base_end & pre_end & ~restart;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt_q <= 16'h0000;
			pre_q <= 6'h00;
		end
		else if (ce)
		begin
			if (restart || base_end)
				cnt_q <= 16'h0000;
			else
				cnt_q <= cnt_q + 16'h0001;
			if (restart || (base_end && pre_end))
				pre_q <= 6'h00;
			else if (base_end)
				pre_q <= pre_q + 6'h01;
		end
	end

endmodule

`default_nettype wire

/* logic/usart_core.sv */
// Serial port core: break send, wake-up on break, clocked master transmit
`default_nettype none

module usart_core
	import usart_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rdata,
	input wire logic rx_dt_i,
	output logic rx_dt_o,
	output logic rx_dt_oe,
	output logic tx_ck_o,
	output logic tx_ck_oe,
	output logic receive_interrupt_flag,
	output logic transmit_interrupt_flag,
	output logic shift_register_empty
);

	logic [7:0] rcv_ctrl_q, tx_ctrl_q, baud_ctrl_q, div_high_q, div_low_q;
	logic [7:0] tx_buffer_q, rcv_data_q, rdata_q;
	logic buf_full_q, buf_full_d, send_break_q, send_break_d;
	logic wake_enable_q, wake_enable_d, wake_armed_q, wake_armed_d;
	logic rcv_flag_q, rcv_flag_d, frame_err_q, overrun_q, overrun_d, rx_ninth_q;
	logic rx_s1_q, rx_s2_q, rx_s3_q;
	tx_state_t tx_state_q, tx_state_d;
	logic [13:0] tx_frame_q, tx_frame_d;
	logic [3:0] tx_left_q, tx_left_d;
	logic tx_half_q, tx_half_d, tx_break_q, tx_break_d;
	rx_state_t rx_state_q, rx_state_d;
	logic [4:0] rx_hcnt_q, rx_hcnt_d;
	logic [8:0] rx_shift_q, rx_shift_d;
	logic ck_pin_q, dt_pin_q, ck_oe_q, dt_oe_q;
	logic tx_tick, rx_tick;

	// Register port decode
	wire wr_ok = wr_en & ce;
	wire rd_ok = rd_en & ce;
	wire wr_rcv = wr_ok & (addr == OFS_RCV_STATUS);
	wire wr_txbuf = wr_ok & (addr == OFS_TX_BUFFER);
	wire wr_txctl = wr_ok & (addr == OFS_TX_STATUS);
	wire wr_baud = wr_ok & (addr == OFS_BAUD_CTRL);
	wire wr_divh = wr_ok & (addr == OFS_DIV_HIGH);
	wire wr_divl = wr_ok & (addr == OFS_DIV_LOW);
	wire rd_rcvdata = rd_ok & (addr == OFS_RCV_DATA);

	// Mode bits
	wire port_en = rcv_ctrl_q[BIT_PORT_EN];
	wire rx_nine = rcv_ctrl_q[BIT_RX_NINE];
	wire rx_req = rcv_ctrl_q[BIT_SINGLE_RX] | rcv_ctrl_q[BIT_CONT_RX];
	wire clk_master = tx_ctrl_q[BIT_CLK_MASTER];
	wire tx_nine = tx_ctrl_q[BIT_TX_NINE];
	wire tx_en = tx_ctrl_q[BIT_TX_EN];
	wire clocked = tx_ctrl_q[BIT_CLOCKED];
	wire high_speed = tx_ctrl_q[BIT_HIGH_SPEED];
	wire tx_ninth = tx_ctrl_q[BIT_TX_NINTH];
	wire clk_pol = baud_ctrl_q[BIT_CLK_POL];
	wire wide_div = baud_ctrl_q[BIT_WIDE_DIV];
	wire sync_master = port_en & clocked & clk_master; // see R16

	// Slave clocking is not supported, so clocked mode without master stays quiet
	wire tx_allowed = port_en & tx_en & (~clocked | (clk_master & ~rx_req)); // see R17

	// Divisor and prescale selection
	wire [15:0] divisor = wide_div ? {div_high_q, div_low_q} : {8'h00, div_low_q}; // see R24
	wire [5:0] pre_async = high_speed ? (wide_div ? PRE_FASTEST : PRE_FAST)
		: (wide_div ? PRE_FAST : PRE_PLAIN);
	wire [5:0] prescale = clocked ? PRE_CLOCKED : pre_async; // see R24

	// Receive line synchroniser edges
	wire rx_line = rx_s2_q;
	wire rx_fall = rx_s3_q & ~rx_s2_q;
	wire rx_rise = ~rx_s3_q & rx_s2_q;

	// Transmit load and bit timing
	wire tx_go = buf_full_q & tx_allowed;
	wire tx_loading = (tx_state_q == TX_LOAD);
	wire tx_shifting = (tx_state_q == TX_SHIFT);
	wire tx_bit_end = tx_shifting & tx_tick & tx_half_q;
	wire tx_done = tx_bit_end & (tx_left_q == 4'h1);
	wire break_done = tx_done & tx_break_q;
	wire load_break = send_break_q & tx_en & ~clocked; // see R08
	wire [13:0] frame_async = tx_nine ? {3'h7, 1'b1, tx_ninth, tx_buffer_q, 1'b0}
		: {4'hF, 1'b1, tx_buffer_q, 1'b0};
	wire [13:0] frame_clocked = tx_nine ? {5'h1F, tx_ninth, tx_buffer_q}
		: {6'h3F, tx_buffer_q};
	wire [13:0] frame_data = clocked ? frame_clocked : frame_async;
	wire [13:0] frame_load = load_break ? BREAK_FRAME : frame_data; // see R07, R09
	wire [3:0] bits_data = (clocked ? CLOCKED_BITS : ASYNC_BITS) + {3'h0, tx_nine};
	wire [3:0] bits_load = load_break ? BREAK_BITS : bits_data; // see R07

	// Asynchronous receiver control
	wire rx_en = port_en & ~clocked & rcv_ctrl_q[BIT_CONT_RX] & ~wake_enable_q; // see R01
	wire rx_idle = (rx_state_q == RX_IDLE);
	wire rx_start = rx_idle & rx_en & rx_fall;
	wire rx_sample = (rx_state_q == RX_BUSY) & rx_tick & ~rx_hcnt_q[0];
	wire [4:0] rx_idx = {1'b0, rx_hcnt_q[4:1]};
	wire rx_at_stop = rx_sample & (rx_idx == (rx_nine ? RX_LAST9 : RX_LAST8));
	wire rx_store = rx_at_stop & ce & ~rcv_flag_q;
	wire rx_overrun = rx_at_stop & ce & rcv_flag_q;
	wire [7:0] rx_byte = rx_nine ? rx_shift_q[7:0] : rx_shift_q[8:1];

	// Wake-up detection, kept alive while the clock enable is low
	wire wake_event = wake_enable_q & ~wake_armed_q & rx_fall; // see R01
	wire wake_done = wake_enable_q & wake_armed_q & rx_rise; // see R03

	baud_gen tx_baud (
		.clk(clk),
		.arst_n(arst_n),
		.ce(ce),
		.restart(tx_loading),
		.divisor(divisor),
		.prescale(prescale),
		.tick(tx_tick)
	);

	baud_gen rx_baud (
		.clk(clk),
		.arst_n(arst_n),
		.ce(ce),
		.restart(rx_start),
		.divisor(divisor),
		.prescale(prescale),
		.tick(rx_tick)
	);

	// Transmit sequencer
	always_comb
	begin
		tx_state_d = tx_state_q;
		tx_frame_d = tx_frame_q;
		tx_left_d = tx_left_q;
		tx_half_d = tx_half_q;
		tx_break_d = tx_break_q;
		case (tx_state_q)
			TX_IDLE:
			begin
				if (tx_go)
					tx_state_d = TX_LOAD; // see R19
			end
			TX_LOAD:
			begin
				tx_state_d = TX_SHIFT; // see R20
				tx_frame_d = frame_load;
				tx_left_d = bits_load;
				tx_half_d = 1'b0;
				tx_break_d = load_break;
			end
			TX_SHIFT:
			begin
				if (tx_tick)
					tx_half_d = ~tx_half_q;
				if (tx_bit_end)
				begin
					tx_frame_d = {1'b1, tx_frame_q[13:1]};
					tx_left_d = tx_left_q - 4'h1;
				end
				if (tx_done)
					tx_state_d = tx_go ? TX_LOAD : TX_IDLE; // see R19
			end
			default:
				tx_state_d = TX_IDLE;
		endcase
		if (!tx_allowed)
			tx_state_d = TX_IDLE;
	end

	// Receive sequencer
	always_comb
	begin
		rx_state_d = rx_state_q;
		rx_hcnt_d = rx_hcnt_q;
		rx_shift_d = rx_shift_q;
		case (rx_state_q)
			RX_IDLE:
			begin
				if (rx_start)
				begin
					rx_state_d = RX_BUSY;
					rx_hcnt_d = 5'h00;
				end
			end
			RX_BUSY:
			begin
				if (rx_tick)
					rx_hcnt_d = rx_hcnt_q + 5'h01;
				if (rx_sample && rx_idx != 5'h00)
					rx_shift_d = {rx_line, rx_shift_q[8:1]};
				if ((rx_sample && rx_idx == 5'h00 && rx_line) || rx_at_stop)
					rx_state_d = RX_IDLE;
			end
			default:
				rx_state_d = RX_IDLE;
		endcase
		if (!rx_en)
			rx_state_d = RX_IDLE;
	end

	// Flag and control next values; a set or a register write wins over a clear
	assign buf_full_d = wr_txbuf | (buf_full_q & ~tx_loading); // see R20, R21
	assign send_break_d = wr_txctl ? wdata[BIT_SEND_BREAK]
		: (send_break_q & ~(break_done & ce)); // see R10
	assign wake_enable_d = wr_baud ? wdata[BIT_WAKE_EN]
		: (wake_enable_q & ~wake_done); // see R03, R06
	assign wake_armed_d = wake_enable_q & (wake_armed_q | rx_fall) & ~wake_done;
	assign rcv_flag_d = wake_event | rx_store | (rcv_flag_q & ~rd_rcvdata); // see R04, R14
	assign overrun_d = rx_overrun | (overrun_q & ~(wr_rcv & ~wdata[BIT_CONT_RX]));

	// Pin drive: data pin only while clocked master transmit is allowed, clock pin per mode
	wire ck_active = tx_shifting & clocked & ~tx_half_q;
	wire tx_line = tx_shifting ? tx_frame_q[0] : 1'b1;
	wire ck_pin_d = clocked ? (ck_active ? ~clk_pol : clk_pol) : tx_line; // see R18
	wire ck_oe_d = port_en & (~clocked | clk_master); // see R16
	wire dt_oe_d = sync_master & tx_allowed; // see R17

	// Read data multiplexer
	wire [7:0] rcv_read = {rcv_ctrl_q[7:3], frame_err_q, overrun_q, rx_ninth_q};
	wire [7:0] tx_read = {tx_ctrl_q[7:4], send_break_q, tx_ctrl_q[2],
		shift_register_empty, tx_ctrl_q[0]}; // see R11, R22
	wire [7:0] baud_read = {1'b0, rx_idle, baud_ctrl_q[5:2], wake_enable_q,
		baud_ctrl_q[0]};
	wire [7:0] flags_read = {6'h00, transmit_interrupt_flag, rcv_flag_q};
	wire [7:0] read_mux =
		(addr == OFS_RCV_STATUS) ? rcv_read :
		(addr == OFS_TX_BUFFER) ? tx_buffer_q :
		(addr == OFS_TX_STATUS) ? tx_read :
		(addr == OFS_BAUD_CTRL) ? baud_read :
		(addr == OFS_DIV_HIGH) ? div_high_q :
		(addr == OFS_DIV_LOW) ? div_low_q :
		(addr == OFS_RCV_DATA) ? rcv_data_q : flags_read;

	assign rdata = rdata_q;
	assign rx_dt_o = dt_pin_q;
	assign rx_dt_oe = dt_oe_q;
	assign tx_ck_o = ck_pin_q;
	assign tx_ck_oe = ck_oe_q;
	assign receive_interrupt_flag = rcv_flag_q;
	assign transmit_interrupt_flag = ~buf_full_q; // see R21
	assign shift_register_empty = (tx_state_q == TX_IDLE); // see R11, R22

	// Receive pin synchroniser runs freely so wake edges are seen without ce
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rx_s1_q <= 1'b1;
			rx_s2_q <= 1'b1;
			rx_s3_q <= 1'b1;
		end
		else
		begin
			rx_s1_q <= rx_dt_i;
			rx_s2_q <= rx_s1_q;
			rx_s3_q <= rx_s2_q;
		end
	end

	// Wake state and receive flag also run without ce
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wake_enable_q <= 1'b0;
			wake_armed_q <= 1'b0;
			rcv_flag_q <= 1'b0;
		end
		else
		begin
			wake_enable_q <= wake_enable_d;
			wake_armed_q <= wake_armed_d;
			rcv_flag_q <= rcv_flag_d;
		end
	end

	// Software registers
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rcv_ctrl_q <= REG_RESET;
			tx_ctrl_q <= REG_RESET;
			baud_ctrl_q <= REG_RESET;
			div_high_q <= DIV_RESET[15:8];
			div_low_q <= DIV_RESET[7:0];
			tx_buffer_q <= REG_RESET;
		end
		else if (ce)
		begin
			if (wr_rcv)
				rcv_ctrl_q <= wdata & RCV_WMASK;
			if (wr_txctl)
				tx_ctrl_q <= wdata & TX_WMASK;
			if (wr_baud)
				baud_ctrl_q <= wdata & BAUD_WMASK;
			if (wr_divh)
				div_high_q <= wdata;
			if (wr_divl)
				div_low_q <= wdata;
			if (wr_txbuf)
				tx_buffer_q <= wdata;
		end
	end

	// Transmit state
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tx_state_q <= TX_IDLE;
			tx_frame_q <= 14'h3FFF;
			tx_left_q <= 4'h0;
			tx_half_q <= 1'b0;
			tx_break_q <= 1'b0;
			buf_full_q <= 1'b0;
			send_break_q <= 1'b0;
		end
		else if (ce)
		begin
			tx_state_q <= tx_state_d;
			tx_frame_q <= tx_frame_d;
			tx_left_q <= tx_left_d;
			tx_half_q <= tx_half_d;
			tx_break_q <= tx_break_d;
			buf_full_q <= buf_full_d;
			send_break_q <= send_break_d;
		end
	end

	// Receive state and captured data
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rx_state_q <= RX_IDLE;
			rx_hcnt_q <= 5'h00;
			rx_shift_q <= 9'h000;
			rcv_data_q <= REG_RESET;
			rx_ninth_q <= 1'b0;
			frame_err_q <= 1'b0;
			overrun_q <= 1'b0;
		end
		else if (ce)
		begin
			rx_state_q <= rx_state_d;
			rx_hcnt_q <= rx_hcnt_d;
			rx_shift_q <= rx_shift_d;
			overrun_q <= overrun_d;
			if (rx_at_stop)
				frame_err_q <= ~rx_line;
			if (rx_store)
			begin
				rcv_data_q <= rx_byte;
				rx_ninth_q <= rx_nine & rx_shift_q[8];
			end
		end
	end

	// Registered pins and read data
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ck_pin_q <= 1'b1;
			ck_oe_q <= 1'b0;
			dt_pin_q <= 1'b1;
			dt_oe_q <= 1'b0;
			rdata_q <= 8'h00;
		end
		else if (ce)
		begin
			ck_pin_q <= ck_pin_d;
			ck_oe_q <= ck_oe_d;
			dt_pin_q <= tx_line;
			dt_oe_q <= dt_oe_d;
			rdata_q <= rd_ok ? read_mux : 8'h00;
		end
	end

endmodule

`default_nettype wire

/* verification/usart_chk.sv */
// Port checker for the serial port core
`default_nettype none

module usart_chk
	import usart_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] rdata,
	input wire logic rx_dt_i,
	input wire logic rx_dt_o,
	input wire logic rx_dt_oe,
	input wire logic tx_ck_o,
	input wire logic tx_ck_oe,
	input wire logic receive_interrupt_flag,
	input wire logic transmit_interrupt_flag,
	input wire logic shift_register_empty
);
	timeunit 1ns;
	timeprecision 1ns;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	logic pol_q;

	// Idle level is only known from what software last wrote
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
			pol_q <= 1'b0;
		else if (wr_en && ce && addr == OFS_BAUD_CTRL)
			pol_q <= wdata[BIT_CLK_POL];

	sequence s_buf_write;
		wr_en && ce && addr == OFS_TX_BUFFER;
	endsequence
	sequence s_start;
		shift_register_empty ##1 !shift_register_empty;
	endsequence

	a_write_clears_flag: assert property (s_buf_write |=> !transmit_interrupt_flag)
		else $error("transmit flag set after buffer write");
	a_flag_only_write: assert property ($fell(transmit_interrupt_flag) |->
		$past(wr_en) && $past(ce) && $past(addr) == OFS_TX_BUFFER)
		else $error("transmit flag fell without buffer write");
	a_load_one_cycle: assert property (s_start |=>
		transmit_interrupt_flag && !$past(transmit_interrupt_flag))
		else $error("shift start not one cycle after load");
	a_flag_at_move: assert property ($rose(transmit_interrupt_flag) |->
		!shift_register_empty)
		else $error("transmit flag rose without a shift load");
	a_rdata_idle: assert property (!(rd_en && ce) |=> rdata == 8'h00)
		else $error("read data outside read answer");
	a_data_needs_clock: assert property (rx_dt_oe |-> tx_ck_oe)
		else $error("data driven without shift clock");
	a_half_duplex: assert property (rx_dt_oe |-> !$rose(receive_interrupt_flag))
		else $error("reception during clocked transmit");
	a_clock_idle: assert property ($fell(rx_dt_oe) |-> tx_ck_o == pol_q)
		else $error("shift clock not at idle level");
	a_read_clears_rcv: assert property (rd_en && ce && addr == OFS_RCV_DATA |=>
		!receive_interrupt_flag)
		else $error("receive flag kept after data read");
	a_empty_readback: assert property (rd_en && ce && addr == OFS_TX_STATUS |=>
		rdata[1] == $past(shift_register_empty))
		else $error("empty bit read differs from port");
endmodule

bind usart_core usart_chk usart_chk_inst (.clk(clk), .arst_n(arst_n), .ce(ce), .addr(addr),
	.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .rx_dt_i(rx_dt_i),
	.rx_dt_o(rx_dt_o), .rx_dt_oe(rx_dt_oe), .tx_ck_o(tx_ck_o), .tx_ck_oe(tx_ck_oe),
	.receive_interrupt_flag(receive_interrupt_flag),
	.transmit_interrupt_flag(transmit_interrupt_flag),
	.shift_register_empty(shift_register_empty));

`default_nettype wire

/* verification/serial_node.sv */
// Remote serial node: async frames both ways, clocked word capture
`default_nettype none

module serial_node
#(
	parameter int BIT_NS = 160
)
(
	input wire logic tx_line,
	input wire logic dt_line,
	input wire logic dt_oe,
	input wire logic pol,
	input wire logic async_on,
	output logic rx_drive
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [7:0] rx_byte;
	logic [7:0] ck_byte;
	logic [8:0] smp;
	int zeros;
	int frames;
	time ck_t;
	time ck_period;

	initial
	begin
		rx_drive = 1'b1;
		frames = 0;
		ck_t = 0;
		ck_period = 0;
	end

	// Bit-centre sampling; an all-zero frame keeps counting until the line rises
	always @(negedge tx_line)
	begin
		if (async_on)
		begin
			#(BIT_NS / 2);
			for (int i = 0; i < 9; i++)
			begin
				#(BIT_NS);
				smp[i] = tx_line;
			end
			zeros = 0;
			if (smp == 9'h000)
			begin
				zeros = 9;
				#(BIT_NS);
				while (!tx_line)
				begin
					zeros++;
					#(BIT_NS);
				end
			end
			rx_byte = smp[7:0];
			frames++;
		end
	end

	// Data is taken as the clock returns to idle, LSB first
	always @(tx_line)
	begin
		if (dt_oe && tx_line == pol)
			ck_byte = {dt_line, ck_byte[7:1]};
		if (dt_oe && tx_line != pol)
		begin
			if (ck_t != 0)
				ck_period = $time - ck_t;
			ck_t = $time;
		end
	end

	task automatic send_low(input int bits);
		#1 rx_drive = 1'b0;
		#(BIT_NS * bits);
		rx_drive = 1'b1;
		#(BIT_NS);
	endtask

	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		#1;
		for (int i = 0; i < 10; i++)
		begin
			rx_drive = f[i];
			#(BIT_NS);
		end
	endtask
endmodule

`default_nettype wire

/* verification/testbench.sv */
// Bench: break send, wake-up on break, clocked master transmit
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import usart_pkg::*;

	logic clk, arst_n, ce, wr_en, rd_en, pol, async_on;
	logic [ADDR_W-1:0] addr;
	logic [7:0] wdata, rdata, rd_val;
	logic rx_dt_o, rx_dt_oe, tx_ck_o, tx_ck_oe, node_drive;
	logic receive_interrupt_flag, transmit_interrupt_flag, shift_register_empty;
	wire logic dt_wire;
	wire logic ck_wire;
	int miscompares, compares, rises;

	assign dt_wire = rx_dt_oe ? rx_dt_o : node_drive;
	// Pull-up holds the clock pin while the port does not drive it
	assign ck_wire = tx_ck_oe ? tx_ck_o : 1'b1;

	usart_core usart_core_inst (.clk(clk), .arst_n(arst_n), .ce(ce), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .rx_dt_i(dt_wire),
		.rx_dt_o(rx_dt_o), .rx_dt_oe(rx_dt_oe), .tx_ck_o(tx_ck_o), .tx_ck_oe(tx_ck_oe),
		.receive_interrupt_flag(receive_interrupt_flag),
		.transmit_interrupt_flag(transmit_interrupt_flag),
		.shift_register_empty(shift_register_empty));
	serial_node serial_node_inst (.tx_line(ck_wire), .dt_line(dt_wire), .dt_oe(rx_dt_oe),
		.pol(pol), .async_on(async_on), .rx_drive(node_drive));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge shift_register_empty)
		rises++;

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] v);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 v = rdata;
		@(posedge clk);
	endtask

	task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
		logic [7:0] v;
		rd(a, v);
		check(v, e);
	endtask

	task automatic wait_empty(input logic lvl);
		for (int i = 0; i < 4000 && shift_register_empty !== lvl; i++)
			@(posedge clk);
	endtask

	task automatic test_done;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Whole run needs about 1200 cycles
	initial
	begin
		#200000;
		miscompares++;
		test_done();
	end

	initial
	begin
		{arst_n, ce, wr_en, rd_en, pol, addr, wdata} = '0;
		{miscompares, compares, rises} = '0;
		async_on = 1'b1;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		ce <= 1'b1;
		@(posedge clk);
		rdchk(OFS_TX_STATUS, 8'h02);
		rdchk(OFS_FLAGS, 8'h02);
		rdchk(OFS_BAUD_CTRL, 8'h40);
		$display("reset test done");

		rises = 0;
		wr(OFS_RCV_STATUS, 8'h80);
		wr(OFS_TX_STATUS, 8'h2C);
		wr(OFS_TX_BUFFER, 8'hFF);
		#1 check({7'h00, transmit_interrupt_flag}, 8'h00);
		repeat (2) @(posedge clk);
		#1 check({6'h00, transmit_interrupt_flag, shift_register_empty}, 8'h02);
		wr(OFS_TX_BUFFER, 8'h55);
		#1 check({7'h00, transmit_interrupt_flag}, 8'h00);
		for (int i = 0; i < 3000 && serial_node_inst.frames < 1; i++)
			@(posedge clk);
		check(8'(serial_node_inst.zeros), 8'd12);
		check(serial_node_inst.rx_byte, 8'h00);
		for (int i = 0; i < 3000 && serial_node_inst.frames < 2; i++)
			@(posedge clk);
		wait_empty(1'b1);
		check(8'(serial_node_inst.frames), 8'd2);
		check(serial_node_inst.rx_byte, 8'h55);
		rdchk(OFS_TX_STATUS, 8'h26);
		rdchk(OFS_FLAGS, 8'h02);
		wr(OFS_BAUD_CTRL, 8'h01);
		rdchk(OFS_BAUD_CTRL, 8'h41);
		check(8'(rises), 8'd1);
		$display("break test done");

		wr(OFS_RCV_STATUS, 8'h90);
		wr(OFS_BAUD_CTRL, 8'h02);
		rdchk(OFS_BAUD_CTRL, 8'h42);
		ce <= 1'b0;
		fork
			serial_node_inst.send_low(13);
			begin
				repeat (40) @(posedge clk);
				#1 check({7'h00, receive_interrupt_flag}, 8'h01);
			end
		join
		@(posedge clk);
		ce <= 1'b1;
		@(posedge clk);
		rdchk(OFS_BAUD_CTRL, 8'h40);
		rd(OFS_RCV_DATA, rd_val);
		check({7'h00, receive_interrupt_flag}, 8'h00);
		serial_node_inst.send_byte(8'hA5);
		for (int i = 0; i < 300 && receive_interrupt_flag !== 1'b1; i++)
			@(posedge clk);
		rdchk(OFS_RCV_DATA, 8'hA5);
		// A 13-bit break sent 13/9 faster than the receiver rate spans nine receiver bits
		serial_node_inst.send_low(9);
		for (int i = 0; i < 300 && receive_interrupt_flag !== 1'b1; i++)
			@(posedge clk);
		rdchk(OFS_RCV_DATA, 8'h00);
		rdchk(OFS_RCV_STATUS, 8'h90);
		$display("wake test done");

		async_on <= 1'b0;
		wr(OFS_DIV_LOW, 8'h01);
		wr(OFS_TX_STATUS, 8'hB0);
		for (int p = 0; p < 2; p++)
		begin
			pol <= p[0];
			wr(OFS_BAUD_CTRL, {3'h0, p[0], 4'h0});
			wr(OFS_TX_BUFFER, p[0] ? 8'hC3 : 8'h3C);
			repeat (30) @(posedge clk);
			check({7'h00, shift_register_empty}, 8'h01);
			wr(OFS_RCV_STATUS, 8'h80);
			wait_empty(1'b0);
			wait_empty(1'b1);
			repeat (3) @(posedge clk);
			check(serial_node_inst.ck_byte, p[0] ? 8'hC3 : 8'h3C);
			check(8'(serial_node_inst.ck_period), 8'd80);
			check({7'h00, ck_wire}, {7'h00, p[0]});
			wr(OFS_RCV_STATUS, 8'h90);
		end
		$display("clocked test done");
		test_done();
	end
endmodule

`default_nettype wire
